// *** hw/fbch_consts.vh ***
`ifndef FBCH_CONSTS_VH
`define FBCH_CONSTS_VH

// ======================================================================
// Command and reply tags
`define FBCH_CMD_ERASE_ALL      8'h01
`define FBCH_CMD_MEM_READ       8'h03
`define FBCH_CMD_PROP_WRITE     8'h0C
`define FBCH_CMD_MASS_UNLOCK    8'h0D
`define FBCH_TAG_PLAIN_REPLY    8'hA0
`define FBCH_TAG_READ_REPLY     8'hA3
`define FBCH_FLAG_DATA_PHASE    8'h01
`define FBCH_FLAG_NONE          8'h00

// ======================================================================
// Status codes
`define FBCH_ST_OK              32'h00000000
`define FBCH_ST_FAIL            32'h00000001
`define FBCH_ST_BAD_ARG         32'h00000004
`define FBCH_ST_MISALIGN        32'h00000065
`define FBCH_ST_OUT_OF_RANGE    32'h00000066
`define FBCH_ST_ACCESS_FAULT    32'h00000067
`define FBCH_ST_PROT_FAULT      32'h00000068
`define FBCH_ST_OP_FAIL         32'h00000069
`define FBCH_ST_UNKNOWN_PROP    32'h0000003C
`define FBCH_ST_READONLY_PROP   32'h0000003D
`define FBCH_ST_PROT_RANGE      32'h000027D8

// ======================================================================
// Security byte
`define FBCH_SEC_BYTE_ADDR      32'h0000040C
`define FBCH_SEC_UNLOCKED_VAL   8'hFE
`define FBCH_SEC_MASS_ERASE_ENABLE_FIELD_LSB       4
`define FBCH_SEC_MASS_ERASE_ENABLE_FIELD_OFF       2'h2

// ======================================================================
// Properties
`define FBCH_PROP_WRITE_CHECK   32'h0000000A
`define FBCH_PROP_VERSION       32'h00000001

`endif

// *** hw/fbch_range_check.v ***
`timescale 1ns/1ps
`default_nettype none

// ======================================================================
// Region check: alignment, containment in flash, protection overlap
module fbch_range_check
#(
  parameter FLASH_BASE = 32'h00000000,
  parameter FLASH_SIZE = 32'h00040000,
  parameter SECTORS    = 32
)
(
  input  wire [31:0]        startAddr,
  input  wire [31:0]        byteCount,
  input  wire [SECTORS-1:0] protMask,
  output wire               misaligned,
  output wire               outOfRange,
  output wire               touchesProt
);

  localparam [31:0] SECT_SIZE = FLASH_SIZE / SECTORS;

  wire [32:0] endAddr;
  wire [SECTORS-1:0] hit;

  // Low two bits of both values must be clear
  assign misaligned = (startAddr[1:0] != 2'h0) | (byteCount[1:0] != 2'h0);  // RULE_07
  // 33-bit end avoids wrap around the top of the address space
  assign endAddr = {1'b0, startAddr} + {1'b0, byteCount};
  assign outOfRange = (startAddr < FLASH_BASE) |
                      (endAddr > ({1'b0, FLASH_BASE} + {1'b0, FLASH_SIZE}));  // RULE_08

  // Each protected sector is checked for overlap with the region
  genvar s;
  generate
    for (s = 0; s < SECTORS; s = s + 1)
    begin : gSect
      wire [32:0] lo = {1'b0, FLASH_BASE} + s * {1'b0, SECT_SIZE};
      wire [32:0] hi = lo + {1'b0, SECT_SIZE};
      assign hit[s] = protMask[s] & ({1'b0, startAddr} < hi) & (endAddr > lo);
    end
  endgenerate
  assign touchesProt = |hit;  // RULE_09

endmodule // fbch_range_check

`default_nettype wire

// *** hw/fbch_handler.v ***
// Functional notes
// RULE_01 - property write: code 0C, id then value
// RULE_02 - read-only property: unchanged, read-only status
// RULE_03 - property write replies plain status only
// RULE_04 - whole erase fails if anything protected
// RULE_05 - whole erase releases security until reset
// RULE_06 - whole erase replies plain status
// RULE_07 - region misaligned start/count gives 101
// RULE_08 - region outside flash gives 102
// RULE_09 - region touching protection gives 10200
// RULE_10 - region reply may carry 103, 104, 105
// RULE_11 - mass erase 0D erases everything
// RULE_12 - mass erase unsecures, programs 0x40C to FE
// RULE_13 - mass erase refused when enable field off
// RULE_14 - memory read: code 03, address, count
// RULE_15 - read allowed unless security protects region
// RULE_16 - host pulls data until count reached
// RULE_17 - read ends with plain status reply
// RULE_18 - read reply A3, data flag, status, count
// RULE_19 - writable property stored, success replied
// RULE_20 - each command completes before next decode
`timescale 1ns/1ps
`default_nettype none

`include "fbch_consts.vh"

module fbch_handler
#(
  parameter FLASH_BASE = 32'h00000000,
  parameter FLASH_SIZE = 32'h00040000,
  parameter SECTORS    = 32,
  parameter REGION_CMD = 8'h02
)
(
  input  wire               clk,
  input  wire               rst,
  // Decoded command packet from framing layer
  input  wire               cmdValid,
  output wire               cmdReady,
  input  wire [7:0]         cmdTag,
  input  wire [31:0]        cmdParam0,
  input  wire [31:0]        cmdParam1,
  // Reply packet to framing layer
  output reg                rspValid,
  input  wire               rspReady,
  output reg  [7:0]         rspTag,
  output reg  [7:0]         rspFlags,
  output reg  [31:0]        rspStatus,
  output reg  [31:0]        rspCount,
  // Data phase: host pulls one word per pull
  input  wire               dataPull,
  output reg                dataValid,
  output reg  [31:0]        dataWord,
  // Memory read port
  output reg                memRdReq,
  output reg  [31:0]        memRdAddr,
  input  wire               memRdAck,
  input  wire [31:0]        memRdData,
  // Flash controller
  output reg                flashReq,
  output reg  [1:0]         flashOp,
  output reg  [31:0]        flashAddr,
  output reg  [31:0]        flashLen,
  output reg  [7:0]         flashWrByte,
  input  wire               flashDone,
  input  wire [2:0]         flashErr,
  // Security and protection state
  input  wire [SECTORS-1:0] protMask,
  input  wire [7:0]         securityByte,
  input  wire               secRegionMatch,
  output reg                secureActive,
  output reg                writeCheck
);

  // ======================================================================
  // States and flash ops
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_ERASE = 8'h02;
  localparam [7:0] S_PROG  = 8'h04;
  localparam [7:0] S_RRSP  = 8'h08;
  localparam [7:0] S_RDATA = 8'h10;
  localparam [7:0] S_RMEM  = 8'h20;
  localparam [7:0] S_FIN   = 8'h40;
  localparam [7:0] S_REPLY = 8'h80;
  localparam [1:0] OP_ALL    = 2'h0;
  localparam [1:0] OP_REGION = 2'h1;
  localparam [1:0] OP_MASS   = 2'h2;
  localparam [1:0] OP_BYTE   = 2'h3;

  reg  [7:0]  state;
  reg  [31:0] remain;
  reg  [31:0] finStatus;
  wire        isMass;
  wire        readBlocked;
  wire        misaligned;
  wire        outOfRange;
  wire        touchesProt;
  wire        anyProt;
  wire        meenOff;
  wire [31:0] flashStatus;

  fbch_range_check
  #(
    .FLASH_BASE (FLASH_BASE),
    .FLASH_SIZE (FLASH_SIZE),
    .SECTORS    (SECTORS)
  )
  uRange
  (
    .startAddr   (cmdParam0),
    .byteCount   (cmdParam1),
    .protMask    (protMask),
    .misaligned  (misaligned),
    .outOfRange  (outOfRange),
    .touchesProt (touchesProt)
  );

  assign anyProt = |protMask;
  assign isMass = (cmdTag == `FBCH_CMD_MASS_UNLOCK);
  // Secured regions stay closed only while security is in force
  assign readBlocked = secureActive & secRegionMatch;
  assign meenOff = securityByte[`FBCH_SEC_MASS_ERASE_ENABLE_FIELD_LSB+1:`FBCH_SEC_MASS_ERASE_ENABLE_FIELD_LSB] == `FBCH_SEC_MASS_ERASE_ENABLE_FIELD_OFF;
  // New commands are only decoded when idle
  assign cmdReady = (state == S_IDLE);  // RULE_20

  // Flash controller error code to status, worst first
  assign flashStatus = flashErr[0] ? `FBCH_ST_ACCESS_FAULT :
                       flashErr[1] ? `FBCH_ST_PROT_FAULT :
                       flashErr[2] ? `FBCH_ST_OP_FAIL : `FBCH_ST_OK;  // RULE_10

  // ======================================================================
  // Command sequencer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state        <= S_IDLE;
      rspValid     <= 1'b0;
      rspTag       <= 8'h00;
      rspFlags     <= 8'h00;
      rspStatus    <= 32'h00000000;
      rspCount     <= 32'h00000000;
      dataValid    <= 1'b0;
      dataWord     <= 32'h00000000;
      memRdReq     <= 1'b0;
      memRdAddr    <= 32'h00000000;
      flashReq     <= 1'b0;
      flashOp      <= 2'h0;
      flashAddr    <= 32'h00000000;
      flashLen     <= 32'h00000000;
      flashWrByte  <= 8'h00;
      secureActive <= 1'b1;  // Security returns on every reset
      writeCheck   <= 1'b0;
      remain       <= 32'h00000000;
      finStatus    <= 32'h00000000;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          rspTag   <= `FBCH_TAG_PLAIN_REPLY;
          rspFlags <= `FBCH_FLAG_NONE;
          rspCount <= 32'h00000000;
          if (cmdValid)
          begin
            // Immediate answer by default; a started flash operation takes it back
            rspValid <= 1'b1;
            state    <= S_REPLY;
            if (cmdTag == `FBCH_CMD_PROP_WRITE)  // RULE_01
            begin
              // Only the write-check property is writable here
              if (cmdParam0 == `FBCH_PROP_WRITE_CHECK)
              begin
                if (cmdParam1[31:1] != 31'h0)
                  rspStatus <= `FBCH_ST_BAD_ARG;  // RULE_03
                else
                begin
                  writeCheck <= cmdParam1[0];  // RULE_19
                  rspStatus  <= `FBCH_ST_OK;
                end
              end
              else if (cmdParam0 == `FBCH_PROP_VERSION)
                rspStatus <= `FBCH_ST_READONLY_PROP;  // RULE_02
              else
                rspStatus <= `FBCH_ST_UNKNOWN_PROP;  // RULE_03
            end
            else if ((cmdTag == `FBCH_CMD_ERASE_ALL) | isMass)
            begin
              // Whole erase stops on protection, mass erase on its enable field
              if (isMass ? meenOff : anyProt)  // RULE_04 RULE_13
                rspStatus <= isMass ? `FBCH_ST_FAIL : `FBCH_ST_PROT_FAULT;
              else
              begin
                flashOp  <= isMass ? OP_MASS : OP_ALL;  // RULE_11
                flashReq <= 1'b1;
                rspValid <= 1'b0;
                state    <= S_ERASE;
              end
            end
            else if (cmdTag == REGION_CMD)
            begin
              // Alignment first, then range, then protection
              if (misaligned | outOfRange | touchesProt)
                rspStatus <= misaligned ? `FBCH_ST_MISALIGN :
                             outOfRange ? `FBCH_ST_OUT_OF_RANGE :
                             `FBCH_ST_PROT_RANGE;  // RULE_07
              else
              begin
                flashOp   <= OP_REGION;
                flashAddr <= cmdParam0;
                flashLen  <= cmdParam1;
                flashReq  <= 1'b1;
                rspValid  <= 1'b0;
                state     <= S_ERASE;
              end
            end
            else if (cmdTag == `FBCH_CMD_MEM_READ)  // RULE_14
            begin
              rspTag    <= `FBCH_TAG_READ_REPLY;  // RULE_18
              rspFlags  <= `FBCH_FLAG_DATA_PHASE;
              memRdAddr <= cmdParam0;
              rspStatus <= readBlocked ? `FBCH_ST_PROT_FAULT : `FBCH_ST_OK;  // RULE_15
              rspCount  <= readBlocked ? 32'h00000000 : cmdParam1;
              remain    <= readBlocked ? 32'h00000000 : cmdParam1;
              state     <= S_RRSP;
            end
            else
              rspStatus <= `FBCH_ST_BAD_ARG;
          end
        end
        S_ERASE:
        begin
          flashReq <= 1'b0;
          if (flashDone)
          begin
            if ((flashErr == 3'h0) & (flashOp == OP_MASS))
            begin
              // Program the security byte to its unlocked value
              flashOp     <= OP_BYTE;  // RULE_12
              flashAddr   <= `FBCH_SEC_BYTE_ADDR;
              flashLen    <= 32'h00000001;
              flashWrByte <= `FBCH_SEC_UNLOCKED_VAL;
              flashReq    <= 1'b1;
              secureActive <= 1'b0;  // RULE_12
              state       <= S_PROG;
            end
            else
            begin
              if ((flashErr == 3'h0) & (flashOp == OP_ALL))
                secureActive <= 1'b0;  // RULE_05
              rspStatus <= flashStatus;  // RULE_06
              rspValid  <= 1'b1;
              state     <= S_REPLY;
            end
          end
        end
        S_PROG:
        begin
          flashReq <= 1'b0;
          if (flashDone)
          begin
            rspStatus <= flashStatus;
            rspValid  <= 1'b1;
            state     <= S_REPLY;
          end
        end
        S_RRSP:
        begin
          if (rspReady)
          begin
            rspValid  <= 1'b0;
            finStatus <= rspStatus;
            state     <= (remain == 32'h0) ? S_FIN : S_RDATA;
          end
        end
        S_RDATA:
        begin
          // Device only answers pulls; the host drives the pace
          if (dataValid & dataPull)  // RULE_16
            dataValid <= 1'b0;
          else if (!dataValid)
          begin
            if (remain == 32'h0)
              state <= S_FIN;
            else
            begin
              memRdReq <= 1'b1;
              state    <= S_RMEM;
            end
          end
        end
        S_RMEM:
        begin
          if (memRdAck)
          begin
            memRdReq  <= 1'b0;
            dataWord  <= memRdData;
            dataValid <= 1'b1;
            memRdAddr <= memRdAddr + 32'h00000004;
            remain    <= (remain > 32'h4) ? remain - 32'h00000004 : 32'h00000000;
            state     <= S_RDATA;
          end
        end
        S_FIN:
        begin
          rspTag    <= `FBCH_TAG_PLAIN_REPLY;  // RULE_17
          rspFlags  <= `FBCH_FLAG_NONE;
          rspCount  <= 32'h00000000;
          rspStatus <= finStatus;
          rspValid  <= 1'b1;
          state     <= S_REPLY;
        end
        S_REPLY:
        begin
          if (rspReady)
          begin
            rspValid <= 1'b0;
            state    <= S_IDLE;  // RULE_20
          end
        end
        default:
        begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // fbch_handler

`default_nettype wire

// *** verif/fbch_handler_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbch_consts.vh"

// ====================================================================
// Port checker for the command handler
module fbch_handler_sva
#(
  parameter             SECTORS    = 32,
  parameter logic [7:0] REGION_CMD = 8'h02
)
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               cmdValid,
  input wire logic               cmdReady,
  input wire logic [7:0]         cmdTag,
  input wire logic [31:0]        cmdParam0,
  input wire logic [31:0]        cmdParam1,
  input wire logic               rspValid,
  input wire logic               rspReady,
  input wire logic [7:0]         rspTag,
  input wire logic [7:0]         rspFlags,
  input wire logic [31:0]        rspStatus,
  input wire logic [31:0]        rspCount,
  input wire logic               dataPull,
  input wire logic               dataValid,
  input wire logic [31:0]        dataWord,
  input wire logic               flashReq,
  input wire logic [1:0]         flashOp,
  input wire logic [31:0]        flashAddr,
  input wire logic [7:0]         flashWrByte,
  input wire logic [SECTORS-1:0] protMask,
  input wire logic [7:0]         securityByte,
  input wire logic               secRegionMatch,
  input wire logic               secureActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A command is taken on an edge with both handshake halves high
  wire take = cmdValid && cmdReady;

  rsp_hold_a: assert property (rspValid && !rspReady |=> rspValid && $stable(rspStatus))
    else $error("reply dropped or changed before taken");
  busy_refuse_a: assert property (rspValid || dataValid |-> !cmdReady)
    else $error("command offered while busy");
  read_reply_a: assert property (take && cmdTag == 8'h03 && !secRegionMatch |=>
    rspValid && rspTag == 8'hA3 && rspFlags == 8'h01 && rspCount == $past(cmdParam1))
    else $error("read reply header wrong");
  prop_reply_a: assert property (take && cmdTag == 8'h0C |=> rspValid && rspTag == 8'hA0)
    else $error("property write reply wrong");
  region_misalign_a: assert property (take && cmdTag == REGION_CMD &&
    (cmdParam0[1:0] != 2'h0 || cmdParam1[1:0] != 2'h0) |-> ##[1:3] rspStatus == 32'h65)
    else $error("misaligned region not refused");
  mass_refuse_a: assert property (take && cmdTag == 8'h0D && securityByte[5:4] == 2'h2
    |=> !flashReq [*4]) else $error("refused mass erase touched flash");
  erase_prot_a: assert property (take && cmdTag == 8'h01 && protMask != '0
    |=> !flashReq [*4]) else $error("erase ran despite protection");
  unlock_byte_a: assert property (flashReq && flashOp == 2'h3 |->
    flashAddr == 32'h0000040C && flashWrByte == 8'hFE) else $error("security byte wrong");
  secure_read_a: assert property (take && cmdTag == 8'h03 && secRegionMatch && secureActive |=>
    rspValid && rspStatus == 32'h68) else $error("secured read served");
  data_hold_a: assert property (dataValid && !dataPull |=> dataValid && $stable(dataWord))
    else $error("data word lost before pull");
  flash_pulse_a: assert property (flashReq |=> !flashReq)
    else $error("flash request longer than a pulse");

  // Main scenarios reached
  cover property (take && cmdTag == 8'h03);
  cover property (flashReq && flashOp == 2'h3);
  cover property (rspValid && rspStatus == 32'h65);
endmodule // fbch_handler_sva

bind fbch_handler fbch_handler_sva #(.SECTORS(SECTORS), .REGION_CMD(REGION_CMD)) i_fbch_handler_sva
(
  .clk, .rst, .cmdValid, .cmdReady, .cmdTag, .cmdParam0, .cmdParam1, .rspValid, .rspReady,
  .rspTag, .rspFlags, .rspStatus, .rspCount, .dataPull, .dataValid, .dataWord, .flashReq,
  .flashOp, .flashAddr, .flashWrByte, .protMask, .securityByte, .secRegionMatch, .secureActive
);

`default_nettype wire

// *** verif/fbch_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Flash controller and memory stand-in
module fbch_flash_model
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        flashReq,
  input  wire logic [1:0]  flashOp,
  input  wire logic [31:0] flashAddr,
  input  wire logic [7:0]  flashWrByte,
  output logic             flashDone,
  output logic [2:0]       flashErr,
  input  wire logic        memRdReq,
  input  wire logic [31:0] memRdAddr,
  output logic             memRdAck,
  output logic [31:0]      memRdData,
  input  wire logic        slow,
  input  wire logic [2:0]  errInject,
  output logic [31:0]      opCount,
  output logic [1:0]       lastOp,
  output logic [31:0]      lastAddr,
  output logic [7:0]       lastByte
);
  logic       busy;
  logic [2:0] cnt;
  logic [1:0] memCnt;

  // Errors ride only on done; read data is junk outside the ack cycle
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      cnt <= 3'h0;
      memCnt <= 2'h0;
      flashDone <= 1'b0;
      flashErr <= 3'h0;
      memRdAck <= 1'b0;
      memRdData <= 32'hA5A5A5A5;
      opCount <= 32'h0;
    end
    else
    begin
      flashDone <= 1'b0;
      flashErr <= 3'h0;
      if (flashReq)
      begin
        busy <= 1'b1;
        cnt <= slow ? 3'h6 : 3'h1;
        opCount <= opCount + 32'h1;
        lastOp <= flashOp;
        lastAddr <= flashAddr;
        lastByte <= flashWrByte;
      end
      else if (busy && cnt == 3'h0)
      begin
        busy <= 1'b0;
        flashDone <= 1'b1;
        flashErr <= errInject;
      end
      else if (busy)
        cnt <= cnt - 3'h1;
      if (memRdReq && !memRdAck && memCnt == 2'h0)
      begin
        memRdAck <= 1'b1;
        memRdData <= memRdAddr ^ 32'h5A5A0000;
        memCnt <= slow ? 2'h2 : 2'h0;
      end
      else
      begin
        memRdAck <= 1'b0;
        memRdData <= ~memRdData;
        if (memRdReq && memCnt != 2'h0)
          memCnt <= memCnt - 2'h1;
      end
    end
  end
endmodule // fbch_flash_model

`default_nettype wire

// *** verif/flash_boot_command_handler_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbch_consts.vh"

// ====================================================================
// Command sequences against the handler
module flash_boot_command_handler_bench;
  localparam logic [7:0] REG_CMD = 8'h02;
  logic        clk, rst, cmdValid, cmdReady, rspValid, rspReady, dataPull, dataValid;
  logic        memRdReq, memRdAck, flashReq, flashDone, secRegionMatch, secureActive;
  logic        writeCheck, slow;
  logic [1:0]  flashOp, lastOp;
  logic [2:0]  flashErr, errIn;
  logic [7:0]  cmdTag, rspTag, rspFlags, flashWrByte, securityByte, lastByte, gTag, gFlags;
  logic [31:0] cmdParam0, cmdParam1, rspStatus, rspCount, dataWord, memRdAddr, memRdData;
  logic [31:0] flashAddr, protMask, lastAddr, opCount, gStat, gCnt;
  int          mismatches = 0;
  int          checks = 0;
  int          i;
  logic [31:0] rA [8] = '{32'h4002, 32'h4000, 32'h3FFF0, 32'h0, 32'h4000, 32'h4000,
                          32'h4000, 32'h4000};
  logic [31:0] rN [8] = '{32'h100, 32'h102, 32'h20, 32'h10, 32'h100, 32'h100, 32'h100, 32'h100};
  logic [2:0]  rE [8] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h0};
  logic [31:0] rS [8] = '{`FBCH_ST_MISALIGN, `FBCH_ST_MISALIGN, `FBCH_ST_OUT_OF_RANGE,
                          `FBCH_ST_PROT_RANGE, `FBCH_ST_ACCESS_FAULT, `FBCH_ST_PROT_FAULT,
                          `FBCH_ST_OP_FAIL, `FBCH_ST_OK};

  fbch_handler #(.REGION_CMD(REG_CMD)) i_fbch_handler
  (
    .clk, .rst, .cmdValid, .cmdReady, .cmdTag, .cmdParam0, .cmdParam1, .rspValid, .rspReady,
    .rspTag, .rspFlags, .rspStatus, .rspCount, .dataPull, .dataValid, .dataWord, .memRdReq,
    .memRdAddr, .memRdAck, .memRdData, .flashReq, .flashOp, .flashAddr, .flashLen(),
    .flashWrByte, .flashDone, .flashErr, .protMask, .securityByte, .secRegionMatch,
    .secureActive, .writeCheck
  );

  fbch_flash_model i_fbch_flash_model
  (
    .clk, .rst, .flashReq, .flashOp, .flashAddr, .flashWrByte, .flashDone, .flashErr,
    .memRdReq, .memRdAddr, .memRdAck, .memRdData, .slow, .errInject(errIn), .opCount,
    .lastOp, .lastAddr, .lastByte
  );

  // ==================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic do_reset;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask

  // Hold the command until the edge that takes it
  task automatic cmd(input logic [7:0] t, input logic [31:0] a, input logic [31:0] b);
    cmdValid <= 1'b1;
    cmdTag <= t;
    cmdParam0 <= a;
    cmdParam1 <= b;
    @(posedge clk);
    repeat (400) if (cmdReady !== 1'b1) @(posedge clk);
    chk("cmdReady", 32'h1, 32'(cmdReady));
    cmdValid <= 1'b0;
  endtask

  // Let the reply stand two cycles so its hold is exercised, then take it
  task automatic get_rsp;
    repeat (400) if (rspValid !== 1'b1) @(posedge clk);
    chk("rspValid", 32'h1, 32'(rspValid));
    repeat (2) @(posedge clk);
    rspReady <= 1'b1;
    @(posedge clk);
    gTag = rspTag;
    gFlags = rspFlags;
    gStat = rspStatus;
    gCnt = rspCount;
    rspReady <= 1'b0;
  endtask

  task automatic op(input logic [7:0] t, input logic [31:0] a, input logic [31:0] b,
                    input logic [31:0] st);
    cmd(t, a, b);
    get_rsp;
    chk("rspStatus", st, gStat);
  endtask

  // Pull late, dataPull high for one edge per word, so each word must stand until taken
  task automatic pull(input logic [31:0] a, input int words);
    for (int w = 0; w < words; w++)
    begin
      @(posedge clk);
      repeat (400) if (dataValid !== 1'b1) @(posedge clk);
      @(posedge clk);
      dataPull <= 1'b1;
      @(posedge clk);
      chk("dataWord", (a + 32'(w) * 32'h4) ^ 32'h5A5A0000, dataWord);
      dataPull <= 1'b0;
    end
  endtask

  // ==================================================================
  // Clock, watchdog and tests
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    #400000;
    mismatches++;
    close_out;
  end

  initial
  begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdTag = 8'h00;
    cmdParam0 = 32'h0;
    cmdParam1 = 32'h0;
    rspReady = 1'b0;
    dataPull = 1'b0;
    protMask = 32'h0;
    securityByte = 8'hFE;
    secRegionMatch = 1'b0;
    slow = 1'b0;
    errIn = 3'h0;
    do_reset;
    chk("secureActive", 32'h1, 32'(secureActive));
    op(`FBCH_CMD_PROP_WRITE, `FBCH_PROP_WRITE_CHECK, 32'h1, `FBCH_ST_OK);
    chk("rspTag", 32'hA0, 32'(gTag));
    chk("writeCheck", 32'h1, 32'(writeCheck));
    op(`FBCH_CMD_PROP_WRITE, `FBCH_PROP_WRITE_CHECK, 32'h5, `FBCH_ST_BAD_ARG);
    op(`FBCH_CMD_PROP_WRITE, `FBCH_PROP_VERSION, 32'h7, `FBCH_ST_READONLY_PROP);
    op(`FBCH_CMD_PROP_WRITE, 32'h77, 32'h0, `FBCH_ST_UNKNOWN_PROP);
    chk("writeCheck", 32'h1, 32'(writeCheck));
    protMask <= 32'h1;
    op(`FBCH_CMD_ERASE_ALL, 32'h0, 32'h0, `FBCH_ST_PROT_FAULT);
    chk("opCount", 32'h0, opCount);
    protMask <= 32'h0;
    slow <= 1'b1;
    op(`FBCH_CMD_ERASE_ALL, 32'h0, 32'h0, `FBCH_ST_OK);
    chk("lastOp", 32'h0, 32'(lastOp));
    chk("secureActive", 32'h0, 32'(secureActive));
    protMask <= 32'h1;
    for (i = 0; i < 8; i++)
    begin
      errIn <= rE[i];
      slow <= i[0];
      op(REG_CMD, rA[i], rN[i], rS[i]);
    end
    errIn <= 3'h0;
    chk("lastOp", 32'h1, 32'(lastOp));
    chk("lastAddr", 32'h4000, lastAddr);
    do_reset;
    chk("secureActive", 32'h1, 32'(secureActive));
    securityByte <= 8'hEF;
    op(`FBCH_CMD_MASS_UNLOCK, 32'h0, 32'h0, `FBCH_ST_FAIL);
    chk("opCount", 32'h0, opCount);
    securityByte <= 8'hFE;
    op(`FBCH_CMD_MASS_UNLOCK, 32'h0, 32'h0, `FBCH_ST_OK);
    chk("opCount", 32'h2, opCount);
    chk("lastAddr", `FBCH_SEC_BYTE_ADDR, lastAddr);
    chk("lastByte", 32'hFE, 32'(lastByte));
    chk("secureActive", 32'h0, 32'(secureActive));
    cmd(`FBCH_CMD_MEM_READ, 32'h100, 32'hA);
    get_rsp;
    chk("rspTag", 32'hA3, 32'(gTag));
    chk("rspFlags", 32'h1, 32'(gFlags));
    chk("rspCount", 32'hA, gCnt);
    pull(32'h100, 3);
    get_rsp;
    chk("rspStatus", `FBCH_ST_OK, gStat);
    chk("rspTag", 32'hA0, 32'(gTag));
    // Security only returns with a reset, so the secured read needs one first
    do_reset;
    secRegionMatch <= 1'b1;
    op(`FBCH_CMD_MEM_READ, 32'h200, 32'h4, `FBCH_ST_PROT_FAULT);
    chk("rspCount", 32'h0, gCnt);
    get_rsp;
    chk("rspStatus", `FBCH_ST_PROT_FAULT, gStat);
    close_out;
  end
endmodule // flash_boot_command_handler_bench

`default_nettype wire
